// ===== design/mscr_consts.svh
/*
 * Offsets, field positions, reset values and code limits of the
 * start-up configuration bank.
 * Assumes inclusion by the package and by the register module only.
 */
`ifndef MSCR_CONSTS_SVH
`define MSCR_CONSTS_SVH

`define MSCR_ADDR_W 8
`define MSCR_OFS_ONE 8'h80
`define MSCR_OFS_TWO 8'h84
`define MSCR_RESET_ONE 32'h0000_0000
`define MSCR_RESET_TWO 32'h0000_0000
`define MSCR_TWO_RSVD_MASK 32'hFFFF_FFE0

`define MSCR_ONE_METHOD_LSB 29
`define MSCR_ONE_THR_LSB 10
`define MSCR_ONE_REL_LSB 8
`define MSCR_ONE_ADV_LSB 6
`define MSCR_ONE_REP_LSB 4
`define MSCR_ONE_SLOW_LSB 0
`define MSCR_TWO_SRC_BIT 30
`define MSCR_TWO_DUTY_LSB 27
`define MSCR_TWO_OLIM_LSB 23

`define MSCR_THR_MIN_CODE 4'h2
`define MSCR_STEP_MV 11'h064
`define MSCR_ADV_STEP_DEG 7'h1E
`define MSCR_SLOW_UNDEF_CODE 4'hA

`endif

// ===== design/mscr_pkg.sv
/*
 * Types of the start-up configuration bank.
 * Assumes the constants header sits beside it.
 */
package mscr_pkg;
   `include "mscr_consts.svh"

   typedef enum logic [1:0] {
      MSCR_ALIGN = 2'h0,
      MSCR_DOUBLE_ALIGN = 2'h1,
      MSCR_POSDET = 2'h2,
      MSCR_SLOW_CYCLE = 2'h3
   } mscr_method_t;

   typedef struct packed {
      mscr_method_t startup_method;
      logic posdet_enable;
      logic [10:0] posdet_current_threshold_mv;
      logic posdet_threshold_ok;
      logic posdet_release_tristate;
      logic posdet_release_ok;
      logic [6:0] posdet_advance_angle_deg;
      logic [2:0] posdet_repeat_runs;
      logic posdet_average;
      logic slow_enable;
      logic [17:0] slow_first_cycle_mhz;
      logic slow_frequency_ok;
      logic openloop_limit_source;
      logic [3:0] openloop_limit_code;
      logic [10:0] openloop_limit_mv;
      logic openloop_limit_ok;
      logic [6:0] openloop_duty_cap_pct;
   } mscr_decoded_t;
endpackage : mscr_pkg

// ===== design/mscr_regs.sv
/*
 * Start-up configuration registers: storage, stored-settings load,
 * read-back, and decoding of the fields into plain engineering values.
 * Assumes a single-cycle write/read port driven by the serial config
 * logic, and a load pulse from the non-volatile store after power-up.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mscr_consts.svh"
module mscr_regs (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [`MSCR_ADDR_W-1:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic store_load,
   input wire logic [31:0] store_one,
   input wire logic [31:0] store_two,
   input wire logic [3:0] general_current_limit,
   output var mscr_pkg::mscr_decoded_t decoded
);
   import mscr_pkg::*;

   logic [31:0] startup_config_one_reg;
   logic [31:0] startup_config_two_reg;
   mscr_decoded_t decoded_next;
   logic [3:0] thr_code, olim_code, slow_code, lim_sel;
   logic [1:0] rel_code, adv_code, rep_code;
   logic [2:0] duty_code;

   // Threshold in millivolts; zero marks a not-applicable code
   function automatic logic [10:0] thr_mv(input logic [3:0] code,
                                         input logic [3:0] min_code);
      logic [10:0] v;
      v = 11'(code) * `MSCR_STEP_MV;
      return (code < min_code) ? 11'h000 : v;
   endfunction : thr_mv

   function automatic logic [17:0] slow_mhz(input logic [3:0] code);
      logic [17:0] v;
      v = 18'h00000;
      unique case (code)
         4'h0: v = 18'h00032;
         4'h1: v = 18'h00064;
         4'h2: v = 18'h000FA;
         4'h3: v = 18'h001F4;
         4'h4: v = 18'h003E8;
         4'h5: v = 18'h007D0;
         4'h6: v = 18'h00BB8;
         4'h7: v = 18'h01388;
         4'h8: v = 18'h02710;
         4'h9: v = 18'h03A98;
         4'hA: v = 18'h00000;
         4'hB: v = 18'h061A8;
         4'hC: v = 18'h0C350;
         4'hD: v = 18'h186A0;
         4'hE: v = 18'h249F0;
         4'hF: v = 18'h30D40;
      endcase
      return v;
   endfunction : slow_mhz

   function automatic logic [6:0] duty_pct(input logic [2:0] code);
      logic [6:0] v;
      v = 7'h0A;
      unique case (code)
         3'h0: v = 7'h0A;
         3'h1: v = 7'h0F;
         3'h2: v = 7'h14;
         3'h3: v = 7'h19;
         3'h4: v = 7'h1E;
         3'h5: v = 7'h28;
         3'h6: v = 7'h32;
         3'h7: v = 7'h64;
      endcase
      return v;
   endfunction : duty_pct

   // Settings load and writes
   // A software write in the same cycle as a load wins: it is newer.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         startup_config_one_reg <= `MSCR_RESET_ONE;
      end else if (cfg_wr && cfg_addr == `MSCR_OFS_ONE) begin
         startup_config_one_reg <= cfg_wdata;
      end else if (store_load) begin
         startup_config_one_reg <= store_one;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         startup_config_two_reg <= `MSCR_RESET_TWO;
      end else if (cfg_wr && cfg_addr == `MSCR_OFS_TWO) begin
         startup_config_two_reg <= cfg_wdata & `MSCR_TWO_RSVD_MASK;
      end else if (store_load) begin
         startup_config_two_reg <= store_two & `MSCR_TWO_RSVD_MASK;
      end
   end

   // Unmapped offsets read as zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
         if (!cfg_rd) begin
            cfg_rdata <= cfg_rdata;
         end else if (cfg_addr == `MSCR_OFS_ONE) begin
            cfg_rdata <= startup_config_one_reg;
         end else if (cfg_addr == `MSCR_OFS_TWO) begin
            cfg_rdata <= startup_config_two_reg;
         end else begin
            cfg_rdata <= 32'h0000_0000;
         end
      end
   end

   assign thr_code = startup_config_one_reg[`MSCR_ONE_THR_LSB +: 4];
   assign rel_code = startup_config_one_reg[`MSCR_ONE_REL_LSB +: 2];
   assign adv_code = startup_config_one_reg[`MSCR_ONE_ADV_LSB +: 2];
   assign rep_code = startup_config_one_reg[`MSCR_ONE_REP_LSB +: 2];
   assign slow_code = startup_config_one_reg[`MSCR_ONE_SLOW_LSB +: 4];
   assign olim_code = startup_config_two_reg[`MSCR_TWO_OLIM_LSB +: 4];
   assign duty_code = startup_config_two_reg[`MSCR_TWO_DUTY_LSB +: 3];
   assign lim_sel = startup_config_two_reg[`MSCR_TWO_SRC_BIT] ?
                    general_current_limit : olim_code;

   always_comb begin
      decoded_next = '0;
      decoded_next.startup_method = mscr_method_t'(
         startup_config_one_reg[`MSCR_ONE_METHOD_LSB +: 2]);
      decoded_next.posdet_enable =
         decoded_next.startup_method == MSCR_POSDET;
      decoded_next.slow_enable =
         decoded_next.startup_method == MSCR_SLOW_CYCLE;
      decoded_next.posdet_current_threshold_mv =
         thr_mv(thr_code, `MSCR_THR_MIN_CODE);
      decoded_next.posdet_threshold_ok = decoded_next.posdet_enable &&
         thr_code >= `MSCR_THR_MIN_CODE;
      decoded_next.posdet_release_tristate = rel_code == 2'h1;
      decoded_next.posdet_release_ok = decoded_next.posdet_enable &&
         !rel_code[1];
      decoded_next.posdet_advance_angle_deg =
         7'(adv_code) * `MSCR_ADV_STEP_DEG;
      decoded_next.posdet_repeat_runs = 3'(rep_code) + 3'h1;
      decoded_next.posdet_average = rep_code != 2'h0;
      decoded_next.slow_first_cycle_mhz = slow_mhz(slow_code);
      decoded_next.slow_frequency_ok = decoded_next.slow_enable &&
         slow_code != `MSCR_SLOW_UNDEF_CODE;
      decoded_next.openloop_limit_source =
         startup_config_two_reg[`MSCR_TWO_SRC_BIT];
      decoded_next.openloop_limit_code = lim_sel;
      // Both limit sources share the 0.1 V step; code 0 is unusable
      decoded_next.openloop_limit_mv = thr_mv(lim_sel, 4'h1);
      decoded_next.openloop_limit_ok = lim_sel != 4'h0;
      decoded_next.openloop_duty_cap_pct = duty_pct(duty_code);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         decoded <= '0;
      end else begin
         decoded <= decoded_next;
      end
   end

   property p_thr;
      @(posedge ref_clk) disable iff (srst)
      $past(thr_code) == 4'h2 && !$past(srst) |->
         decoded.posdet_current_threshold_mv == 11'h0C8;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold decode");

   property p_rel;
      @(posedge ref_clk) disable iff (srst)
      decoded.posdet_release_ok |-> !$past(rel_code[1]);
   endproperty
   a_rel: assert property (p_rel) else $error("release code");

   property p_adv;
      @(posedge ref_clk) disable iff (srst)
      $past(adv_code) == 2'h3 && !$past(srst) |->
         decoded.posdet_advance_angle_deg == 7'h5A;
   endproperty
   a_adv: assert property (p_adv) else $error("advance angle");

   property p_rep;
      @(posedge ref_clk) disable iff (srst)
      decoded.posdet_average |-> decoded.posdet_repeat_runs >= 3'h2;
   endproperty
   a_rep: assert property (p_rep) else $error("repeat count");

   property p_slow;
      @(posedge ref_clk) disable iff (srst)
      decoded.slow_frequency_ok |->
         decoded.slow_first_cycle_mhz != 18'h00000 && decoded.slow_enable;
   endproperty
   a_slow: assert property (p_slow) else $error("slow frequency");

   sequence s_write_two;
      cfg_wr && cfg_addr == `MSCR_OFS_TWO;
   endsequence
   sequence s_read_two;
      cfg_rd && cfg_addr == `MSCR_OFS_TWO && !cfg_wr && !store_load;
   endsequence
   property p_two;
      @(posedge ref_clk) disable iff (srst)
      s_write_two ##1 s_read_two |=>
         cfg_rvalid &&
         cfg_rdata == ($past(cfg_wdata, 2) & `MSCR_TWO_RSVD_MASK);
   endproperty
   a_two: assert property (p_two) else $error("register two");

   property p_src;
      @(posedge ref_clk) disable iff (srst)
      $past(startup_config_two_reg[`MSCR_TWO_SRC_BIT]) && !$past(srst) |->
         decoded.openloop_limit_code == $past(general_current_limit);
   endproperty
   a_src: assert property (p_src) else $error("limit source");

   property p_duty;
      @(posedge ref_clk) disable iff (srst)
      $past(duty_code) == 3'h7 && !$past(srst) |->
         decoded.openloop_duty_cap_pct == 7'h64;
   endproperty
   a_duty: assert property (p_duty) else $error("duty cap");

   property p_gate;
      @(posedge ref_clk) disable iff (srst)
      !decoded.posdet_enable |->
         !decoded.posdet_threshold_ok && !decoded.posdet_release_ok;
   endproperty
   a_gate: assert property (p_gate) else $error("method gating");

   property p_na;
      @(posedge ref_clk) disable iff (srst)
      $past(thr_code) < 4'h2 |-> !decoded.posdet_threshold_ok;
   endproperty
   a_na: assert property (p_na) else $error("unusable code");
endmodule : mscr_regs
`default_nettype wire

// ===== testbench/motor_startup_config_regs_bench.sv
/*
 * Self-checking bench for the start-up configuration registers.
 * Assumes the package and register module are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_startup_config_regs_bench;
   import mscr_pkg::*;
   logic ref_clk, srst, cfg_wr, cfg_rd, cfg_rvalid, store_load;
   logic [7:0] cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, store_one, store_two;
   logic [3:0] general_current_limit;
   mscr_decoded_t decoded;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;
   int slow_tab [16] = '{50, 100, 250, 500, 1000, 2000, 3000, 5000, 10000,
      15000, 0, 25000, 50000, 100000, 150000, 200000};
   int duty_tab [8] = '{10, 15, 20, 25, 30, 40, 50, 100};

   mscr_regs i_mscr_regs (
      .ref_clk(ref_clk),
      .srst(srst),
      .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid),
      .store_load(store_load),
      .store_one(store_one),
      .store_two(store_two),
      .general_current_limit(general_current_limit),
      .decoded(decoded)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Whole run is well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   // Every task is entered just after an edge and leaves the same way
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input bit hold);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      step();
      // Held strobe lets the next transfer follow with no idle cycle
      if (!hold)
         cfg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input bit hold);
      cfg_rd = 1'b1;
      cfg_addr = a;
      step();
      if (!hold)
         cfg_rd = 1'b0;
      chk(32'(cfg_rvalid), 32'h1);
      chk(cfg_rdata, exp);
   endtask : rd

   task automatic t_reset();
      rd(8'h80, 32'h0, 1'b1);
      rd(8'h84, 32'h0, 1'b0);
      chk(32'(decoded.openloop_duty_cap_pct), 32'hA);
      chk(32'(decoded.posdet_repeat_runs), 32'h1);
      chk(32'(decoded.slow_first_cycle_mhz), 32'h32);
      chk(32'(decoded.openloop_limit_ok), 32'h0);
      chk(32'(decoded.openloop_limit_mv), 32'h0);
   endtask : t_reset

   task automatic t_two();
      logic [31:0] d;
      int lim;
      for (int c = 0; c < 8; c++) begin
         lim = c[0] ? 15 - c : c + 1;
         general_current_limit = 4'(15 - c);
         d = {1'b1, c[0], c[2:0], 4'(c + 1), 23'h7F_FFFF};
         wr(8'h84, d, 1'b0);
         step();
         chk(32'(decoded.openloop_duty_cap_pct), duty_tab[c]);
         chk(32'(decoded.openloop_limit_source), c % 2);
         chk(32'(decoded.openloop_limit_code), lim);
         chk(32'(decoded.openloop_limit_mv), lim * 100);
         chk(32'(decoded.openloop_limit_ok), 32'h1);
         rd(8'h84, d & 32'hFFFF_FFE0, 1'b0);
      end
   endtask : t_two

   // Every method against every code, so gating of flags shows
   task automatic t_one();
      logic [31:0] d;
      int r;
      int e;
      mscr_decoded_t q;
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 16; i++) begin
            r = i % 4;
            d = {1'b0, 2'(m), 15'h0, 4'(i), 2'(r), 2'(r), 2'(r), 4'(i)};
            wr(8'h80, d, 1'b0);
            step();
            q = decoded;
            chk(32'(q.startup_method), m);
            chk(32'(q.posdet_enable), m == 2);
            chk(32'(q.slow_enable), m == 3);
            e = i < 2 ? 0 : i * 100;
            chk(32'(q.posdet_current_threshold_mv), e);
            chk(32'(q.posdet_threshold_ok), m == 2 && i >= 2);
            chk(32'(q.posdet_release_tristate), r == 1);
            chk(32'(q.posdet_release_ok), m == 2 && r < 2);
            chk(32'(q.posdet_advance_angle_deg), r * 30);
            chk(32'(q.posdet_repeat_runs), r + 1);
            chk(32'(q.posdet_average), r != 0);
            chk(32'(q.slow_first_cycle_mhz), slow_tab[i]);
            chk(32'(q.slow_frequency_ok), m == 3 && i != 10);
         end
      end
      rd(8'h80, d, 1'b0);
   endtask : t_one

   task automatic t_misc();
      wr(8'h88, 32'hFFFF_FFFF, 1'b0);
      rd(8'h88, 32'h0, 1'b0);
      step();
      chk(32'(cfg_rvalid), 32'h0);
      wr(8'h84, 32'hA5A5_A5A5, 1'b1);
      // Read in the write's own cycle still sees the old word
      cfg_wdata = 32'h5A5A_5A5A;
      rd(8'h84, 32'hA5A5_A5A0, 1'b1);
      cfg_wr = 1'b0;
      rd(8'h84, 32'h5A5A_5A40, 1'b0);
      store_one = 32'h1111_1111;
      store_two = 32'h2222_2222;
      store_load = 1'b1;
      step();
      store_load = 1'b0;
      rd(8'h80, 32'h1111_1111, 1'b1);
      rd(8'h84, 32'h2222_2220, 1'b0);
      store_load = 1'b1;
      wr(8'h80, 32'h3333_3333, 1'b0);
      store_load = 1'b0;
      rd(8'h80, 32'h3333_3333, 1'b0);
   endtask : t_misc

   initial begin
      srst = 1'b1;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 32'h0;
      store_load = 1'b0;
      store_one = 32'h0;
      store_two = 32'h0;
      general_current_limit = 4'h7;
      repeat (8) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      t_reset();
      t_two();
      t_one();
      t_misc();
      give_verdict();
   end
endmodule : motor_startup_config_regs_bench
`default_nettype wire
